// file: hdl/dacreg_pkg.sv
// constants and carrier types for the dual-channel converter control registers
package dacreg_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;
  localparam int unsigned CW = 12;

  // register offsets
  localparam logic [AW-1:0] ADDR_CH1_CODE = 8'h19;
  localparam logic [AW-1:0] ADDR_CH0_CODE = 8'h1C;
  localparam logic [AW-1:0] ADDR_CFG      = 8'h1F;
  localparam logic [AW-1:0] ADDR_TRIG     = 8'h20;

  // reset values
  localparam logic [DW-1:0] CODE_RESET = 16'h0000;
  localparam logic [DW-1:0] CFG_RESET  = 16'h0FFF;
  localparam logic [DW-1:0] TRIG_RESET = 16'h0000;

  // code register layout
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned CODE_MSB = 15;
  localparam logic [CW-1:0] CUR_MODE_MASK = 12'hFF0;
  localparam logic [CW-1:0] CODE_ZERO     = 12'h000;
  localparam logic [CW-1:0] CODE_MID      = 12'h800;

  // configuration layout
  localparam int unsigned CFG_WIN_LATCH = 15;
  localparam int unsigned CFG_LOCK      = 14;
  localparam int unsigned CFG_ROW_SEL   = 13;
  localparam int unsigned CFG_INT_REF   = 12;
  localparam int unsigned CFG_VPDN0_LSB = 10;
  localparam int unsigned CFG_IPDN0     = 9;
  localparam int unsigned CFG_VPDN1_LSB = 1;
  localparam int unsigned CFG_IPDN1     = 0;
  localparam logic [DW-1:0] CFG_RSVD_MASK = 16'h01F8;
  localparam logic [AW-1:0] ROW_ADDR0     = 8'h00;
  localparam logic [AW-1:0] ROW_ADDR1     = 8'h01;

  // trigger layout
  localparam int unsigned TRIG_KEY_LSB   = 12;
  localparam int unsigned TRIG_POR_LSB   = 8;
  localparam int unsigned TRIG_LOAD      = 7;
  localparam int unsigned TRIG_CLEAR     = 6;
  localparam int unsigned TRIG_DUMP      = 4;
  localparam int unsigned TRIG_PROTECT   = 3;
  localparam int unsigned TRIG_ROW_READ  = 2;
  localparam int unsigned TRIG_PROGRAM   = 1;
  localparam int unsigned TRIG_RESTORE   = 0;
  localparam logic [3:0]  UNLOCK_KEY     = 4'h5;
  localparam logic [3:0]  POR_KEY        = 4'hA;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dacreg_req_t;

  typedef struct packed {
    logic soft_por;
    logic sync_load;
    logic output_clear;
    logic fault_dump;
    logic protect;
    logic row_read;
    logic mem_program;
    logic mem_restore;
  } dacreg_act_t;

endpackage

// file: hdl/dacreg_chan_out.sv
// per-channel output code stage with sync load and clear
module dacreg_chan_out
  import dacreg_pkg::*;
(
  input  wire logic          clk_in,         // system clock
  input  wire logic          rst_n_in,       // synchronised reset, active low
  input  wire logic          soft_rst_in,    // software power-on reset pulse
  input  wire logic [CW-1:0] code_in,        // stored channel code
  input  wire logic          current_mode_in, // channel in current-output mode
  input  wire logic          sync_en_in,     // output waits for sync load
  input  wire logic          load_in,        // sync load pulse
  input  wire logic          clear_in,       // output clear pulse
  input  wire logic          clear_mid_in,   // clear to mid-code
  output logic [CW-1:0]      code_out        // code presented to the converter
);

  logic [CW-1:0] eff_code;

  // RULE2: current mode
  assign eff_code = current_mode_in ? (code_in & CUR_MODE_MASK) : code_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_out <= CODE_ZERO;
    end else if (soft_rst_in) begin
      code_out <= CODE_ZERO;
    // RULE11: clear output
    end else if (clear_in) begin
      code_out <= clear_mid_in ? CODE_MID : CODE_ZERO;
    // RULE10: sync load
    end else if (!sync_en_in || load_in) begin
      code_out <= eff_code;
    end
  end

endmodule

// file: hdl/dacreg_top.sv
// control register bank of the dual-channel converter
//
// Contract
// RULE1: code register holds 12-bit straight binary in bits 15-4, low bits ignored.
// RULE2: current mode uses only upper eight code bits.
// RULE3: config bit 15 selects latching window-comparator output.
// RULE4: config bit 14 locks all registers against writes; the trigger key bits 15-12 are still stored while locked.
// RULE5: unlock needs key 0101 in trigger 15-12, then lock bit written zero.
// RULE6: config bit 13 selects fault-dump row 0x00 or 0x01.
// RULE7: host enables internal reference before dependent gain settings.
// RULE8: voltage power-down 2-bit, current power-down 1-bit, both reset powered down.
// RULE9: pattern 1010 in trigger 11-8 issues a full software reset.
// RULE10: trigger bit 7 loads outputs of sync-enabled channels.
// RULE11: trigger bit 6 clears codes and outputs to zero or mid.
// RULE12: trigger bit 4 starts fault dump, self-clearing.
// RULE13: trigger bit 3 starts protect function, self-clearing.
// RULE14: trigger bit 2 reads one memory row, self-clearing.
// RULE15: trigger bit 1 programs memory from registers, self-clearing.
// RULE16: trigger bit 0 restores registers from memory, self-clearing.
// RULE17: action bits read zero; writing zero does nothing.
module dacreg_top
  import dacreg_pkg::*;
(
  input  wire logic         clk_in,                          // 10 MHz clock
  input  wire logic         rst_n_in,                        // async reset, active low
  input  wire dacreg_req_t  req_in,                          // register access request
  input  wire logic [1:0]   current_output_mode_in,          // per channel current mode
  input  wire logic [1:0]   sync_update_en_in,               // per channel sync load enable
  input  wire logic [1:0]   clear_level_select_in,           // per channel clear to mid
  output logic [DW-1:0]     rdata_out,                       // read data
  output logic              rvalid_out,                      // read data valid
  output dacreg_act_t       action_out,                      // action pulses
  output logic              window_compare_latch_enable_out, // latching comparator
  output logic              register_lock_out,               // registers locked
  output logic [AW-1:0]     dump_row_addr_out,               // fault-dump row address
  output logic              int_ref_enable_out,              // internal reference on
  output logic [3:0]        voltage_power_down_mode_out,     // ch0 [3:2], ch1 [1:0]
  output logic [1:0]        current_power_down_out,          // per channel current pdn
  output logic [1:0][CW-1:0] chan_code_out                   // per channel output code
);

  logic [1:0]          rst_q;
  logic                rst_n;
  logic [DW-1:0]       cfg_q;
  logic [1:0][CW-1:0]  code_q;
  logic [3:0]          key_q;
  logic                armed_q;
  dacreg_act_t         act_q;
  dacreg_act_t         act_d;
  logic                locked;
  logic                wr_cfg;
  logic                wr_trig;
  logic [1:0]          wr_code;
  logic [DW-1:0]       rd_mux;

  // reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  assign locked    = cfg_q[CFG_LOCK];
  assign wr_cfg    = req_in.wr && (req_in.addr == ADDR_CFG);
  assign wr_trig   = req_in.wr && (req_in.addr == ADDR_TRIG);
  assign wr_code[0] = req_in.wr && (req_in.addr == ADDR_CH0_CODE);
  assign wr_code[1] = req_in.wr && (req_in.addr == ADDR_CH1_CODE);

  // unlock key arming
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      key_q   <= TRIG_RESET[15:12];
    end else if (act_q.soft_por) begin
      armed_q <= 1'b0;
      key_q   <= TRIG_RESET[15:12];
    end else if (wr_trig) begin
      key_q <= req_in.wdata[15:12];
      // RULE5: key arms unlock
      if (req_in.wdata[15:12] == UNLOCK_KEY) begin
        armed_q <= 1'b1;
      end
    end else if (wr_cfg) begin
      armed_q <= 1'b0;
    end
  end

  // configuration register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
    // RULE9: full reset
    end else if (act_q.soft_por) begin
      cfg_q <= CFG_RESET;
    end else if (wr_cfg) begin
      // RULE4: locked blocks writes
      if (!locked) begin
        cfg_q <= (req_in.wdata & ~CFG_RSVD_MASK) | (CFG_RESET & CFG_RSVD_MASK);
      // RULE5: lock cleared after key
      end else if (armed_q && !req_in.wdata[CFG_LOCK]) begin
        cfg_q[CFG_LOCK] <= 1'b0;
      end
    end
  end

  // channel code registers
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_code
      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          code_q[ch] <= CODE_RESET[CODE_MSB:CODE_LSB];
        end else if (act_q.soft_por) begin
          code_q[ch] <= CODE_RESET[CODE_MSB:CODE_LSB];
        // RULE11: clear registers
        end else if (act_q.output_clear) begin
          code_q[ch] <= clear_level_select_in[ch] ? CODE_MID : CODE_ZERO;
        // RULE1: code in bits 15-4
        end else if (wr_code[ch] && !locked) begin
          code_q[ch] <= req_in.wdata[CODE_MSB:CODE_LSB];
        end
      end

      dacreg_chan_out u_chan (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n),
        .soft_rst_in     (act_q.soft_por),
        .code_in         (code_q[ch]),
        .current_mode_in (current_output_mode_in[ch]),
        .sync_en_in      (sync_update_en_in[ch]),
        .load_in         (act_q.sync_load),
        .clear_in        (act_q.output_clear),
        .clear_mid_in    (clear_level_select_in[ch]),
        .code_out        (chan_code_out[ch])
      );
    end
  endgenerate

  // RULE17: trigger writes
  always_comb begin
    act_d = '0;
    if (wr_trig && !locked && !act_q.soft_por) begin
      // RULE9: reset key
      act_d.soft_por     = (req_in.wdata[11:8] == POR_KEY);
      // RULE10: sync load
      act_d.sync_load    = req_in.wdata[TRIG_LOAD];
      // RULE11: clear
      act_d.output_clear = req_in.wdata[TRIG_CLEAR];
      // RULE12: fault dump
      act_d.fault_dump   = req_in.wdata[TRIG_DUMP];
      // RULE13: protect
      act_d.protect      = req_in.wdata[TRIG_PROTECT];
      // RULE14: row read
      act_d.row_read     = req_in.wdata[TRIG_ROW_READ];
      // RULE15: program
      act_d.mem_program  = req_in.wdata[TRIG_PROGRAM];
      // RULE16: restore
      act_d.mem_restore  = req_in.wdata[TRIG_RESTORE];
    end
  end

  // action pulses last one cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end
  assign action_out = act_q;

  // read mux
  always_comb begin
    rd_mux = '0;
    case (req_in.addr)
      ADDR_CH0_CODE: rd_mux = {code_q[0], 4'h0};
      ADDR_CH1_CODE: rd_mux = {code_q[1], 4'h0};
      ADDR_CFG:      rd_mux = cfg_q;
      // RULE17: action bits read zero
      ADDR_TRIG:     rd_mux = {key_q, 12'h000};
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out  <= '0;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      if (req_in.rd) begin
        rdata_out <= rd_mux;
      end
    end
  end

  // configuration fields to the analog side
  // RULE3: latch select
  assign window_compare_latch_enable_out = cfg_q[CFG_WIN_LATCH];
  assign register_lock_out               = cfg_q[CFG_LOCK];
  // RULE6: dump row select
  assign dump_row_addr_out = cfg_q[CFG_ROW_SEL] ? ROW_ADDR1 : ROW_ADDR0;
  assign int_ref_enable_out = cfg_q[CFG_INT_REF];
  // RULE8: power-down fields
  assign voltage_power_down_mode_out = {cfg_q[CFG_VPDN0_LSB+1:CFG_VPDN0_LSB],
                                        cfg_q[CFG_VPDN1_LSB+1:CFG_VPDN1_LSB]};
  assign current_power_down_out      = {cfg_q[CFG_IPDN0], cfg_q[CFG_IPDN1]};

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_por_write;
    wr_trig && !locked && !act_q.soft_por && (req_in.wdata[11:8] == POR_KEY);
  endsequence

  sequence s_por_done;
    action_out.soft_por ##1 (cfg_q == CFG_RESET && code_q == '0 && !armed_q);
  endsequence

  sequence s_key_write;
    wr_trig && !act_q.soft_por && (req_in.wdata[15:12] == UNLOCK_KEY);
  endsequence

  sequence s_trig_accept;
    wr_trig && !locked && !act_q.soft_por;
  endsequence

  sequence s_unlock_write;
    wr_cfg && !req_in.wdata[CFG_LOCK] && !act_q.soft_por;
  endsequence

  a_por_sequence: assert property (s_por_write |=> s_por_done) // RULE9
    else $error("software reset did not restore registers");

  a_lock_holds_code: assert property ( // RULE4
    (wr_code[0] && locked && !act_q.output_clear && !act_q.soft_por)
      |=> code_q[0] == $past(code_q[0]))
    else $error("locked code register changed");

  a_unlock_needs_key: assert property ($fell(cfg_q[CFG_LOCK]) // RULE5
      |-> ($past(armed_q) || $past(act_q.soft_por)))
    else $error("lock cleared without key");

  a_unlock_sequence: assert property ( // RULE5
    (s_key_write ##1 (!wr_cfg && !act_q.soft_por) ##1 (s_unlock_write and locked))
      |=> !register_lock_out)
    else $error("key then lock write did not unlock");

  a_locked_no_action: assert property ((wr_trig && locked) |=> action_out == '0) // RULE4
    else $error("action issued while locked");

  a_trig_reads_zero: assert property ( // RULE17
    (req_in.rd && req_in.addr == ADDR_TRIG) |=> (rvalid_out && rdata_out[11:0] == 12'h000))
    else $error("trigger action bits read nonzero");

  a_clear_level: assert property ( // RULE11
    (action_out.output_clear && !action_out.soft_por)
      |=> (code_q[0] == ($past(clear_level_select_in[0]) ? CODE_MID : CODE_ZERO)
           && chan_code_out[0] == code_q[0]))
    else $error("clear did not set code level");

  a_cfg_write_takes: assert property ( // RULE3
    (wr_cfg && !locked && !act_q.soft_por)
      |=> (window_compare_latch_enable_out == $past(req_in.wdata[CFG_WIN_LATCH])
           && voltage_power_down_mode_out[3:2] == $past(req_in.wdata[11:10])
           && dump_row_addr_out == ($past(req_in.wdata[CFG_ROW_SEL]) ? ROW_ADDR1 : ROW_ADDR0)))
    else $error("config write not applied");

  a_sync_holds: assert property ( // RULE10
    (sync_update_en_in[0] && !action_out.sync_load && !action_out.output_clear
      && !action_out.soft_por) |=> $stable(chan_code_out[0]))
    else $error("sync channel output moved without load");

  a_load_applies: assert property ( // RULE10
    (action_out.sync_load && !action_out.output_clear && !action_out.soft_por
      && !current_output_mode_in[0]) |=> chan_code_out[0] == $past(code_q[0]))
    else $error("sync load did not update output");

  a_current_mask: assert property ( // RULE2
    (current_output_mode_in[1] && !sync_update_en_in[1]) |=> chan_code_out[1][3:0] == 4'h0)
    else $error("current mode output used low code bits");

  a_load_needs_write: assert property ( // RULE10
    action_out.sync_load |-> $past(wr_trig) && $past(req_in.wdata[TRIG_LOAD]))
    else $error("sync load pulse without trigger write");

  a_clear_needs_write: assert property ( // RULE11
    action_out.output_clear |-> $past(wr_trig) && $past(req_in.wdata[TRIG_CLEAR]))
    else $error("clear pulse without trigger write");

  a_dump_needs_write: assert property ( // RULE12
    action_out.fault_dump |-> $past(wr_trig) && $past(req_in.wdata[TRIG_DUMP]))
    else $error("fault dump pulse without trigger write");

  a_protect_needs_write: assert property ( // RULE13
    action_out.protect |-> $past(wr_trig) && $past(req_in.wdata[TRIG_PROTECT]))
    else $error("protect pulse without trigger write");

  a_row_needs_write: assert property ( // RULE14
    action_out.row_read |-> $past(wr_trig) && $past(req_in.wdata[TRIG_ROW_READ]))
    else $error("row read pulse without trigger write");

  a_program_needs_write: assert property ( // RULE15
    action_out.mem_program |-> $past(wr_trig) && $past(req_in.wdata[TRIG_PROGRAM]))
    else $error("program pulse without trigger write");

  a_restore_needs_write: assert property ( // RULE16
    action_out.mem_restore |-> $past(wr_trig) && $past(req_in.wdata[TRIG_RESTORE]))
    else $error("restore pulse without trigger write");

  a_por_needs_key: assert property ( // RULE9
    action_out.soft_por |-> $past(wr_trig) && ($past(req_in.wdata[11:8]) == POR_KEY))
    else $error("software reset without key pattern");

  a_write_launches: assert property ( // RULE17
    s_trig_accept
      |=> action_out[6:0] == {$past(req_in.wdata[7:6]), $past(req_in.wdata[4:0])})
    else $error("trigger write did not launch its actions");

  a_pulse_self_clears: assert property (!wr_trig |=> action_out == '0) // RULE17
    else $error("action pulse stayed without trigger write");

  a_code_low_zero: assert property ( // RULE1
    (req_in.rd && (req_in.addr == ADDR_CH0_CODE || req_in.addr == ADDR_CH1_CODE))
      |=> rdata_out[3:0] == 4'h0)
    else $error("code read showed ignored low bits");

  a_code_write_takes: assert property ( // RULE1
    (wr_code[1] && !locked && !act_q.output_clear && !act_q.soft_por)
      |=> code_q[1] == $past(req_in.wdata[CODE_MSB:CODE_LSB]))
    else $error("code write not stored");

  a_locked_cfg_kept: assert property ( // RULE4
    (wr_cfg && locked && !act_q.soft_por)
      |=> (cfg_q & 16'hBFFF) == ($past(cfg_q) & 16'hBFFF))
    else $error("locked configuration changed");

  a_cfg_disarms_key: assert property (wr_cfg |=> !armed_q) // RULE5
    else $error("unlock key stayed armed after config write");

  a_pdn_write_takes: assert property ( // RULE8
    (wr_cfg && !locked && !act_q.soft_por)
      |=> (current_power_down_out[1] == $past(req_in.wdata[CFG_IPDN0])
           && current_power_down_out[0] == $past(req_in.wdata[CFG_IPDN1])))
    else $error("current power-down write not applied");

endmodule

// file: test/dacreg_host.sv
// host-side model that drives the register port of the control bank
module dacreg_host
  import dacreg_pkg::*;
(
  input  wire logic          clk_in,    // system clock
  output dacreg_req_t        req_out,   // register access request
  input  wire logic [DW-1:0] rdata_in,  // read data
  input  wire logic          rvalid_in  // read data valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial req_out = '0;

  // one-cycle request; idle addr and wdata show inverted values, never the last ones; wr and rd go to zero
  task automatic access(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic write_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    access(1'b1, a, d);
  endtask

  task automatic read_reg(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic v);
    access(1'b0, a, 16'h0000);
    #1;
    d = rdata_in;
    v = rvalid_in;
  endtask

  task automatic unlock(input logic [DW-1:0] cfg);
    write_reg(ADDR_TRIG, {UNLOCK_KEY, 12'h000});
    write_reg(ADDR_CFG, cfg & 16'hBFFF);
  endtask
endmodule

// file: test/dacreg_top_tb.sv
// self-checking bench for the converter control register bank
module dacreg_top_tb
  import dacreg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk_in = 1'b0;
  logic                 rst_n_in;
  dacreg_req_t          req;
  logic [1:0]           cmode;
  logic [1:0]           sync_en;
  logic [1:0]           clr_sel;
  logic [DW-1:0]        rdata;
  logic                 rvalid;
  dacreg_act_t          act;
  logic                 latch;
  logic                 lock;
  logic [AW-1:0]        row;
  logic                 ref_en;
  logic [3:0]           vpdn;
  logic [1:0]           ipdn;
  logic [1:0][CW-1:0]   code;
  int                   num_errors = 0;
  int                   compares = 0;

  always #50 clk_in = ~clk_in;

  dacreg_top dut (
    .clk_in                          (clk_in),
    .rst_n_in                        (rst_n_in),
    .req_in                          (req),
    .current_output_mode_in          (cmode),
    .sync_update_en_in               (sync_en),
    .clear_level_select_in           (clr_sel),
    .rdata_out                       (rdata),
    .rvalid_out                      (rvalid),
    .action_out                      (act),
    .window_compare_latch_enable_out (latch),
    .register_lock_out               (lock),
    .dump_row_addr_out               (row),
    .int_ref_enable_out              (ref_en),
    .voltage_power_down_mode_out     (vpdn),
    .current_power_down_out          (ipdn),
    .chan_code_out                   (code)
  );

  dacreg_host host (
    .clk_in    (clk_in),
    .req_out   (req),
    .rdata_in  (rdata),
    .rvalid_in (rvalid)
  );

  task automatic test_done();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input string what, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    logic          v;
    host.read_reg(a, d, v);
    chk("read valid", 16'h0001, {15'h0000, v});
    chk(what, exp, d);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    host.write_reg(a, d);
    #1;
  endtask

  // both channel outputs against one code
  task automatic chk_out(input logic [CW-1:0] exp);
    for (int c = 0; c < 2; c++) chk("channel output", {4'h0, exp}, {4'h0, code[c]});
  endtask

  function automatic logic [DW-1:0] cfg_outs();
    return {latch, lock, ref_en, row[4:0], vpdn, ipdn, 2'b00};
  endfunction

  initial begin
    #500000;
    num_errors++;
    test_done();
  end

  initial begin
    rst_n_in <= 1'b0;
    cmode <= 2'b00;
    sync_en <= 2'b00;
    clr_sel <= 2'b00;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd("cfg reset", ADDR_CFG, 16'h0FFF);
    rd("trigger reset", ADDR_TRIG, 16'h0000);
    rd("ch1 reset", ADDR_CH1_CODE, 16'h0000);
    chk("cfg outputs reset", 16'h00FC, cfg_outs());
    // reference enabled before anything that needs it
    wr(ADDR_CFG, 16'hB000);
    chk("cfg outputs", 16'hA100, cfg_outs());
    chk("row address", 16'h0001, {8'h00, row});
    rd("cfg readback", ADDR_CFG, 16'hB1F8);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, 16'((m << 10) | (m << 1)));
      chk("power-down mode", 16'((m << 2) | m), {12'h000, vpdn});
    end
    chk("cfg outputs pdn", 16'h00F0, cfg_outs());
    wr(ADDR_CH0_CODE, 16'hABCD);
    wr(ADDR_CH1_CODE, 16'hABCD);
    rd("ch0 code", ADDR_CH0_CODE, 16'hABC0);
    chk_out(12'hABC);
    @(posedge clk_in);
    cmode <= 2'b11;
    repeat (3) @(posedge clk_in);
    chk_out(12'hAB0);
    @(posedge clk_in);
    cmode <= 2'b00;
    sync_en <= 2'b11;
    wr(ADDR_CH0_CODE, 16'h1230);
    wr(ADDR_CH1_CODE, 16'h1230);
    repeat (2) @(posedge clk_in);
    chk_out(12'hAB0);
    wr(ADDR_TRIG, 16'h0080);
    chk("load action", 16'h0040, {8'h00, act});
    repeat (2) @(posedge clk_in);
    chk_out(12'h123);
    @(posedge clk_in);
    clr_sel <= 2'b10;
    wr(ADDR_TRIG, 16'h0040);
    chk("clear action", 16'h0020, {8'h00, act});
    rd("cleared code", ADDR_CH1_CODE, 16'h8000);
    chk("ch0 cleared output", 16'h0000, {4'h0, code[0]});
    chk("ch1 cleared output", 16'h0800, {4'h0, code[1]});
    for (int b = 0; b < 5; b++) begin
      wr(ADDR_TRIG, 16'(1 << b));
      chk("action pulse", 16'(1 << b), {8'h00, act});
      rd("trigger self-clear", ADDR_TRIG, 16'h0000);
    end
    wr(ADDR_TRIG, 16'h0000);
    chk("zero write action", 16'h0000, {8'h00, act});
    wr(ADDR_CFG, 16'hB000);
    wr(ADDR_TRIG, 16'h0500);
    chk("other reset pattern", 16'h0000, {8'h00, act});
    wr(ADDR_TRIG, 16'h0A00);
    chk("soft reset action", 16'h0080, {8'h00, act});
    rd("cfg after soft reset", ADDR_CFG, 16'h0FFF);
    rd("code after soft reset", ADDR_CH1_CODE, 16'h0000);
    wr(ADDR_CFG, 16'h4000);
    chk("lock set", 16'h0001, {15'h0000, lock});
    wr(ADDR_CH0_CODE, 16'h5550);
    rd("locked code", ADDR_CH0_CODE, 16'h0000);
    wr(ADDR_TRIG, 16'h0008);
    chk("locked action", 16'h0000, {8'h00, act});
    wr(ADDR_CFG, 16'h0000);
    chk("lock without key", 16'h0001, {15'h0000, lock});
    host.unlock(16'h0000);
    #1;
    chk("lock after key", 16'h0000, {15'h0000, lock});
    rd("key readback", ADDR_TRIG, 16'h5000);
    rd("unmapped read", 8'h30, 16'h0000);
    test_done();
  end
endmodule
